// ---- ilmd_top.sv ----
// peripheral interrupt routing to the core interrupt controller, plus
// the debug freeze control register on the private peripheral port
// assumes peripheral requests are levels on CLOCK and the halt flag
// comes from the debug domain

// What this block does
// - every peripheral request drives one fixed core line, 0 to 79
// - four serial transceiver requests go to lines 65 to 68 in order
// - random generator request goes to line 73
// - touch module request goes to line 75
// - audio serial request goes to line 53
// - backup system control request goes to line 38
// - 32-bit freeze register at 0xe0042000, reset to zero
// - bit 0 with core halted holds the watchdog counter
// - bit 1 with core halted holds async timer prescaler and counter
// - bit 2 with core halted freezes the event controller
// - freeze register is reached only on the private peripheral port
module ilmd_top (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // peripheral requests
    input wire logic FLASH_IRQ,
    input wire logic [ilmd_pkg::NUM_DMA-1:0] DMA_IRQ,
    input wire logic CRC_IRQ,
    input wire logic USB_IRQ,
    input wire logic [ilmd_pkg::NUM_EVENT-1:0] EVENT_IRQ,
    input wire logic AES_IRQ,
    input wire logic PWR_IRQ,
    input wire logic SYSCTRL_IRQ,
    input wire logic FREQ_IRQ,
    input wire logic [ilmd_pkg::NUM_GPIO-1:0] GPIO_IRQ,
    input wire logic BACKUP_PWR_IRQ,
    input wire logic BACKUP_SYSCTRL_IRQ,
    input wire logic [ilmd_pkg::NUM_ATIMER-1:0] ATIMER_IRQ,
    input wire logic WATCHDOG_IRQ,
    input wire logic [ilmd_pkg::NUM_EXT-1:0] EXT_IRQ,
    input wire logic AUDIO_SERIAL_IRQ,
    input wire logic SPI_IRQ,
    input wire logic [ilmd_pkg::NUM_TIMER-1:0] TIMER_IRQ,
    input wire logic [ilmd_pkg::NUM_TWO_WIRE_LO-1:0] TWO_WIRE_LO_IRQ,
    input wire logic [ilmd_pkg::NUM_SERIAL-1:0] SERIAL_IRQ,
    input wire logic ADC_IRQ,
    input wire logic DAC_IRQ,
    input wire logic COMPARATOR_IRQ,
    input wire logic BITSTREAM_DAC_IRQ,
    input wire logic RANDOM_GEN_IRQ,
    input wire logic CAPTURE_IRQ,
    input wire logic TOUCH_MODULE_IRQ,
    input wire logic [ilmd_pkg::NUM_TWO_WIRE_HI-1:0] TWO_WIRE_HI_IRQ,
    input wire logic LCD_IRQ,
    // core interrupt controller lines
    output logic [ilmd_pkg::LINES-1:0] CORE_IRQ,
    // debug halt from the core
    input wire logic CORE_HALTED,
    // private peripheral register port
    input wire logic PPB_SEL,
    input wire logic PPB_WRITE,
    input wire logic [ilmd_pkg::ADDR_W-1:0] PPB_ADDR,
    input wire logic [ilmd_pkg::DATA_W-1:0] PPB_WDATA,
    output logic [ilmd_pkg::DATA_W-1:0] PPB_RDATA,
    output logic PPB_ACK,
    // freeze controls to the peripherals
    output logic WATCHDOG_FREEZE,
    output logic ASYNC_TIMER_FREEZE,
    output logic EVENT_CONTROLLER_FREEZE
);

    import ilmd_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [LINES-1:0] irq_d;
    logic [LINES-1:0] irq_q;
    logic [FRZ_W-1:0] frz_d;
    logic [FRZ_W-1:0] frz_q;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rdata_q;
    logic ack_q;
    logic halted;
    logic [FRZ_W-1:0] hold_d;
    logic [FRZ_W-1:0] hold_q;
    logic hit;
    logic wr_hit;
    logic rd_hit;
    logic live_q;

    // ----------------------------------------------------------------
    // request line map
    // ----------------------------------------------------------------

    // each source owns one fixed line; the map never changes
    assign irq_d[LN_FLASH] = FLASH_IRQ;
    assign irq_d[LN_DMA +: NUM_DMA] = DMA_IRQ;
    assign irq_d[LN_CRC] = CRC_IRQ;
    assign irq_d[LN_USB] = USB_IRQ;
    assign irq_d[LN_EVENT +: NUM_EVENT] = EVENT_IRQ;
    assign irq_d[LN_AES] = AES_IRQ;
    assign irq_d[LN_PWR] = PWR_IRQ;
    assign irq_d[LN_SYSCTRL] = SYSCTRL_IRQ;
    assign irq_d[LN_FREQ] = FREQ_IRQ;
    assign irq_d[LN_GPIO +: NUM_GPIO] = GPIO_IRQ;
    assign irq_d[LN_BACKUP_PWR] = BACKUP_PWR_IRQ;
    assign irq_d[LN_BACKUP_SYSCTRL] = BACKUP_SYSCTRL_IRQ;
    assign irq_d[LN_ATIMER +: NUM_ATIMER] = ATIMER_IRQ;
    assign irq_d[LN_WATCHDOG] = WATCHDOG_IRQ;
    assign irq_d[LN_EXT +: NUM_EXT] = EXT_IRQ;
    assign irq_d[LN_AUDIO_SERIAL] = AUDIO_SERIAL_IRQ;
    assign irq_d[LN_SPI] = SPI_IRQ;
    assign irq_d[LN_TIMER +: NUM_TIMER] = TIMER_IRQ;
    assign irq_d[LN_TWO_WIRE_LO +: NUM_TWO_WIRE_LO] = TWO_WIRE_LO_IRQ;
    assign irq_d[LN_SERIAL +: NUM_SERIAL] = SERIAL_IRQ;
    assign irq_d[LN_ADC] = ADC_IRQ;
    assign irq_d[LN_DAC] = DAC_IRQ;
    assign irq_d[LN_COMPARATOR] = COMPARATOR_IRQ;
    assign irq_d[LN_BITSTREAM_DAC] = BITSTREAM_DAC_IRQ;
    assign irq_d[LN_RANDOM_GEN] = RANDOM_GEN_IRQ;
    assign irq_d[LN_CAPTURE] = CAPTURE_IRQ;
    assign irq_d[LN_TOUCH] = TOUCH_MODULE_IRQ;
    assign irq_d[LN_UNUSED] = 1'b0;
    assign irq_d[LN_TWO_WIRE_HI +: NUM_TWO_WIRE_HI] = TWO_WIRE_HI_IRQ;
    assign irq_d[LN_LCD] = LCD_IRQ;

    // one register stage so every line leaves from a flip-flop
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            irq_q <= '0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // ----------------------------------------------------------------
    // freeze control register
    // ----------------------------------------------------------------

    // decode: only the private peripheral port reaches the register
    assign hit = PPB_SEL && (PPB_ADDR == FRZ_ADDR);
    assign wr_hit = hit && PPB_WRITE;
    assign rd_hit = hit && !PPB_WRITE;
    // upper bits are dropped on write and read back as zero
    assign frz_d = wr_hit ? PPB_WDATA[FRZ_W-1:0] : frz_q;
    assign rdata_d = rd_hit ? {{(DATA_W-FRZ_W){1'b0}}, frz_q} : '0;

    // storage, read data and acknowledge
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            frz_q <= FRZ_RESET[FRZ_W-1:0];
            rdata_q <= '0;
            ack_q <= 1'b0;
        end else begin
            frz_q <= frz_d;
            rdata_q <= rdata_d;
            ack_q <= PPB_SEL;
        end
    end

    // ----------------------------------------------------------------
    // debug halt and freeze outputs
    // ----------------------------------------------------------------

    // the halt flag comes from the debug domain
    ilmd_sync3 i_ilmd_sync3 (
        .CLOCK(CLOCK),
        .RST_B(RST_B),
        .async_in(CORE_HALTED),
        .sync_out(halted)
    );

    // a peripheral is held only while its bit is set and the core halts
    assign hold_d = halted ? frz_q : '0;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            hold_q <= '0;
            live_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
            live_q <= 1'b1;
        end
    end

    assign CORE_IRQ = irq_q;
    assign PPB_RDATA = rdata_q;
    assign PPB_ACK = ack_q;
    assign WATCHDOG_FREEZE = hold_q[FRZ_WATCHDOG];
    assign ASYNC_TIMER_FREEZE = hold_q[FRZ_ATIMER];
    assign EVENT_CONTROLLER_FREEZE = hold_q[FRZ_EVENT];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------

    property p_dma_lines;
        @(posedge CLOCK) disable iff (!RST_B)
        live_q |-> CORE_IRQ[16:1] == $past(DMA_IRQ);
    endproperty
    a_dma_lines: assert property (p_dma_lines)
        else $error("dma requests not on lines 1 to 16");

    property p_serial_lines;
        @(posedge CLOCK) disable iff (!RST_B)
        live_q |-> CORE_IRQ[68:65] == $past(SERIAL_IRQ);
    endproperty
    a_serial_lines: assert property (p_serial_lines)
        else $error("serial requests not on lines 65 to 68");

    property p_random_line;
        @(posedge CLOCK) disable iff (!RST_B)
        $rose(RANDOM_GEN_IRQ) |=> CORE_IRQ[73];
    endproperty
    a_random_line: assert property (p_random_line)
        else $error("random generator request missing on line 73");

    property p_touch_line;
        @(posedge CLOCK) disable iff (!RST_B)
        live_q |-> CORE_IRQ[75] == $past(TOUCH_MODULE_IRQ);
    endproperty
    a_touch_line: assert property (p_touch_line)
        else $error("touch request not on line 75");

    property p_audio_line;
        @(posedge CLOCK) disable iff (!RST_B)
        $fell(AUDIO_SERIAL_IRQ) |=> !CORE_IRQ[53];
    endproperty
    a_audio_line: assert property (p_audio_line)
        else $error("audio request did not drop on line 53");

    property p_backup_line;
        @(posedge CLOCK) disable iff (!RST_B)
        live_q |-> CORE_IRQ[38] == $past(BACKUP_SYSCTRL_IRQ);
    endproperty
    a_backup_line: assert property (p_backup_line)
        else $error("backup control request not on line 38");

    property p_write_read;
        @(posedge CLOCK) disable iff (!RST_B)
        (PPB_SEL && PPB_WRITE && PPB_ADDR == FRZ_ADDR)
        |=> frz_q == $past(PPB_WDATA[FRZ_W-1:0]);
    endproperty
    a_write_read: assert property (p_write_read)
        else $error("freeze register did not return written value");

    property p_watchdog_hold;
        @(posedge CLOCK) disable iff (!RST_B)
        live_q |-> WATCHDOG_FREEZE == $past(frz_q[0] && halted);
    endproperty
    a_watchdog_hold: assert property (p_watchdog_hold)
        else $error("watchdog freeze wrong");

    property p_atimer_hold;
        @(posedge CLOCK) disable iff (!RST_B)
        !halted ##1 1'b1 |-> !ASYNC_TIMER_FREEZE;
    endproperty
    a_atimer_hold: assert property (p_atimer_hold)
        else $error("async timer frozen while core runs");

    property p_event_hold;
        @(posedge CLOCK) disable iff (!RST_B)
        (frz_q[2] && halted) |=> EVENT_CONTROLLER_FREEZE;
    endproperty
    a_event_hold: assert property (p_event_hold)
        else $error("event controller not frozen");

    property p_reserved_zero;
        @(posedge CLOCK) disable iff (!RST_B)
        PPB_RDATA[31:3] == 29'h0 && !CORE_IRQ[76];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits or spare line not zero");

    property p_ack_pulse;
        @(posedge CLOCK) disable iff (!RST_B)
        live_q |-> PPB_ACK == $past(PPB_SEL);
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("acknowledge does not follow select by one cycle");

    property p_other_addr;
        @(posedge CLOCK) disable iff (!RST_B)
        (PPB_SEL && PPB_ADDR != FRZ_ADDR)
        |=> PPB_RDATA == 32'h0 && $stable(frz_q);
    endproperty
    a_other_addr: assert property (p_other_addr)
        else $error("access to another address reached the register");

    property p_flash_line;
        @(posedge CLOCK) disable iff (!RST_B)
        live_q |-> CORE_IRQ[0] == $past(FLASH_IRQ);
    endproperty
    a_flash_line: assert property (p_flash_line)
        else $error("flash request not on line 0");

    property p_ext_lines;
        @(posedge CLOCK) disable iff (!RST_B)
        live_q |-> CORE_IRQ[52:45] == $past(EXT_IRQ);
    endproperty
    a_ext_lines: assert property (p_ext_lines)
        else $error("external requests not on lines 45 to 52");

    property p_lcd_line;
        @(posedge CLOCK) disable iff (!RST_B)
        live_q |-> CORE_IRQ[79] == $past(LCD_IRQ);
    endproperty
    a_lcd_line: assert property (p_lcd_line)
        else $error("display request not on line 79");

endmodule

// ---- ilmd_pkg.sv ----
// constants for the interrupt line map and debug freeze block
// assumes one 50 MHz system clock and an active-low asynchronous reset
package ilmd_pkg;

    // ----------------------------------------------------------------
    // core interrupt controller request lines
    // ----------------------------------------------------------------
    localparam int LINES = 80;
    localparam int LN_FLASH = 0;
    localparam int LN_DMA = 1;
    localparam int NUM_DMA = 16;
    localparam int LN_CRC = 17;
    localparam int LN_USB = 18;
    localparam int LN_EVENT = 19;
    localparam int NUM_EVENT = 2;
    localparam int LN_AES = 21;
    localparam int LN_PWR = 22;
    localparam int LN_SYSCTRL = 23;
    localparam int LN_FREQ = 24;
    localparam int LN_GPIO = 25;
    localparam int NUM_GPIO = 12;
    localparam int LN_BACKUP_PWR = 37;
    localparam int LN_BACKUP_SYSCTRL = 38;
    localparam int LN_ATIMER = 39;
    localparam int NUM_ATIMER = 5;
    localparam int LN_WATCHDOG = 44;
    localparam int LN_EXT = 45;
    localparam int NUM_EXT = 8;
    localparam int LN_AUDIO_SERIAL = 53;
    localparam int LN_SPI = 54;
    localparam int LN_TIMER = 55;
    localparam int NUM_TIMER = 6;
    localparam int LN_TWO_WIRE_LO = 61;
    localparam int NUM_TWO_WIRE_LO = 4;
    localparam int LN_SERIAL = 65;
    localparam int NUM_SERIAL = 4;
    localparam int LN_ADC = 69;
    localparam int LN_DAC = 70;
    localparam int LN_COMPARATOR = 71;
    localparam int LN_BITSTREAM_DAC = 72;
    localparam int LN_RANDOM_GEN = 73;
    localparam int LN_CAPTURE = 74;
    localparam int LN_TOUCH = 75;
    localparam int LN_UNUSED = 76;
    localparam int LN_TWO_WIRE_HI = 77;
    localparam int NUM_TWO_WIRE_HI = 2;
    localparam int LN_LCD = 79;

    // ----------------------------------------------------------------
    // debug freeze control register
    // ----------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam logic [31:0] FRZ_ADDR = 32'he0042000;
    localparam logic [31:0] FRZ_RESET = 32'h00000000;
    localparam int FRZ_W = 3;
    localparam int FRZ_WATCHDOG = 0;
    localparam int FRZ_ATIMER = 1;
    localparam int FRZ_EVENT = 2;

endpackage

// ---- ilmd_sync3.sv ----
// three-stage synchroniser for a level arriving from another domain
// assumes the level is slow compared with the system clock
module ilmd_sync3 (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // level in and clean level out
    input wire logic async_in,
    output logic sync_out
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;

    // ----------------------------------------------------------------
    // capture chain; the output follows once stages two and three agree
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                out_q <= s3_q;
            end
        end
    end

    assign sync_out = out_q;

endmodule

// ---- ilmd_core_model.sv ----
// partner model: the core interrupt controller's request inputs
// assumes request lines are active-high levels on CLOCK
module ilmd_core_model (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // request lines in, record of lines seen out
    input wire logic [ilmd_pkg::LINES-1:0] core_irq,
    output logic [ilmd_pkg::LINES-1:0] seen_q
);
    timeunit 1ns;
    timeprecision 1ns;
    import ilmd_pkg::*;
    // remember every line raised since reset, one flag per line
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            seen_q <= '0;
        end else begin
            seen_q <= seen_q | core_irq;
        end
    end
endmodule

// ---- ilmd_top_test.sv ----
// self-checking bench for the line map and debug freeze block
// assumes ilmd_pkg, ilmd_top and ilmd_core_model are compiled first
module ilmd_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import ilmd_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic CLOCK = 1'b0;
    logic RST_B = 1'b0;
    logic [LINES-1:0] src = '0;
    logic halt = 1'b0;
    logic sel = 1'b0;
    logic wr = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [LINES-1:0] irq;
    logic [LINES-1:0] seen;
    logic [31:0] rdata;
    logic ack, wdf, atf, evf;
    logic [31:0] frz;
    int fail_count = 0;
    int n_compared = 0;
    // freeze outputs gathered as a word, bit order of the register
    assign frz = {29'h0, evf, atf, wdf};
    // device under test, request i of src lands on line i, except src[76], which drives nothing
    ilmd_top i_ilmd_top (
        .CLOCK(CLOCK), .RST_B(RST_B),
        .FLASH_IRQ(src[0]), .DMA_IRQ(src[16:1]),
        .CRC_IRQ(src[17]), .USB_IRQ(src[18]), .EVENT_IRQ(src[20:19]),
        .AES_IRQ(src[21]), .PWR_IRQ(src[22]), .SYSCTRL_IRQ(src[23]),
        .FREQ_IRQ(src[24]), .GPIO_IRQ(src[36:25]),
        .BACKUP_PWR_IRQ(src[37]), .BACKUP_SYSCTRL_IRQ(src[38]),
        .ATIMER_IRQ(src[43:39]), .WATCHDOG_IRQ(src[44]),
        .EXT_IRQ(src[52:45]), .AUDIO_SERIAL_IRQ(src[53]),
        .SPI_IRQ(src[54]), .TIMER_IRQ(src[60:55]),
        .TWO_WIRE_LO_IRQ(src[64:61]), .SERIAL_IRQ(src[68:65]),
        .ADC_IRQ(src[69]), .DAC_IRQ(src[70]), .COMPARATOR_IRQ(src[71]),
        .BITSTREAM_DAC_IRQ(src[72]), .RANDOM_GEN_IRQ(src[73]),
        .CAPTURE_IRQ(src[74]), .TOUCH_MODULE_IRQ(src[75]),
        .TWO_WIRE_HI_IRQ(src[78:77]), .LCD_IRQ(src[79]),
        .CORE_IRQ(irq), .CORE_HALTED(halt),
        .PPB_SEL(sel), .PPB_WRITE(wr), .PPB_ADDR(addr),
        .PPB_WDATA(wdata), .PPB_RDATA(rdata), .PPB_ACK(ack),
        .WATCHDOG_FREEZE(wdf), .ASYNC_TIMER_FREEZE(atf),
        .EVENT_CONTROLLER_FREEZE(evf)
    );
    ilmd_core_model i_ilmd_core_model (
        .CLOCK(CLOCK), .RST_B(RST_B), .core_irq(irq), .seen_q(seen)
    );
    // ------------------------------------------------------------
    // clock, verdict, compares and bus access
    // ------------------------------------------------------------
    initial begin
        forever #10 CLOCK = ~CLOCK;
    end
    task automatic test_done;
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk_irq(input logic [LINES-1:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle select strobe; ack and read data stand for one cycle
    // after the taking edge, so they are picked up before it ends
    task automatic bus(input logic w, input logic [31:0] a, d,
                       output logic [31:0] q);
        @(negedge CLOCK);
        sel = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        @(negedge CLOCK);
        chk_word({31'h0, ack}, 32'h1);
        q = rdata;
        sel = 1'b0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] q;
        chk_irq(irq, '0);
        chk_word(frz, 32'h0);
        bus(1'b0, FRZ_ADDR, 32'h0, q);
        chk_word(q, 32'h0);
    endtask
    // raise one request alone, expect only its own line one cycle on
    task automatic t_map(input int n);
        logic [LINES-1:0] exp;
        exp = '0;
        if (n != 76) exp[n] = 1'b1;
        @(negedge CLOCK);
        src = '0;
        src[n] = 1'b1;
        @(negedge CLOCK);
        chk_irq(irq, exp);
    endtask
    task automatic t_lines;
        logic [LINES-1:0] all;
        all = '1;
        all[76] = 1'b0;
        for (int i = 0; i < LINES; i++) t_map(i);
        t_map(65);
        t_map(66);
        t_map(67);
        t_map(68);
        t_map(73);
        t_map(75);
        t_map(53);
        t_map(38);
        t_map(76);
        @(negedge CLOCK);
        src = '1;
        @(negedge CLOCK);
        chk_irq(irq, all);
        chk_irq(seen, all);
        src = '0;
    endtask
    // reserved bits, other addresses, write then read back
    task automatic t_reg;
        logic [31:0] q;
        bus(1'b1, FRZ_ADDR, 32'hffffffff, q);
        bus(1'b0, FRZ_ADDR, 32'h0, q);
        chk_word(q, 32'h7);
        bus(1'b1, 32'h400e2000, 32'h0, q);
        bus(1'b0, 32'h400e2000, 32'h0, q);
        chk_word(q, 32'h0);
        bus(1'b0, FRZ_ADDR, 32'h0, q);
        chk_word(q, 32'h7);
        bus(1'b1, FRZ_ADDR, 32'h5, q);
        bus(1'b0, FRZ_ADDR, 32'h0, q);
        chk_word(q, 32'h5);
    endtask
    // one freeze bit set: only its peripheral held, only while halted
    task automatic t_freeze(input int b);
        logic [31:0] q;
        logic [31:0] exp;
        exp = 32'h1 << b;
        bus(1'b1, FRZ_ADDR, exp, q);
        repeat (6) @(negedge CLOCK);
        chk_word(frz, 32'h0);
        halt = 1'b1;
        repeat (6) @(negedge CLOCK);
        chk_word(frz, exp);
        halt = 1'b0;
        repeat (6) @(negedge CLOCK);
        chk_word(frz, 32'h0);
    endtask
    // reset in mid-run clears the freeze register and the lines again
    task automatic t_rerun;
        @(negedge CLOCK);
        RST_B = 1'b0;
        repeat (2) @(negedge CLOCK);
        RST_B = 1'b1;
        t_reset;
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(negedge CLOCK);
        RST_B = 1'b1;
        t_reset;
        t_lines;
        t_reg;
        t_freeze(FRZ_WATCHDOG);
        t_freeze(FRZ_ATIMER);
        t_freeze(FRZ_EVENT);
        t_rerun;
        test_done;
    end
    initial begin
        repeat (2000) @(posedge CLOCK);
        fail_count++;
        test_done;
    end
endmodule
